// ### verilog/tieu_unit.sv
`timescale 1ns/10ps
module tieu_unit
  import tieu_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // reset sources from the core
  input  wire tieu_rst_s               rst_src,
  // instruction boundary
  input  wire logic                    instr_done,
  // trap conditions
  input  wire tieu_math_s              math_ev,
  input  wire tieu_addr_s              addr_ev,
  input  wire logic                    sp_load,
  input  wire logic [15:0]             sp_value,
  input  wire logic [15:0]             stack_limit_reg,
  input  wire logic                    osc_fail,
  // interrupt sources
  input  wire logic [NUM_IRQ-1:0]      irq_event,
  input  wire logic [NUM_IRQ-1:0]      irq_flag_clr,
  input  wire logic [NUM_IRQ-1:0]      irq_enable_regs,
  input  wire logic [NUM_IRQ-1:0][2:0] irq_priority,
  // status word access
  input  wire logic                    lvl_wr,
  input  wire logic [2:0]              lvl_wdata,
  input  wire logic [4:0]              stat_low,
  input  wire logic [23:0]             pc_in,
  input  wire logic                    irq_return,
  input  wire tieu_frame_s             pop_frame,
  // configuration
  input  wire logic                    alt_vector_select,
  input  wire logic [15:0]             cause_clr,
  // reset towards the core
  output logic                         core_reset_r,
  output logic [23:0]                  reset_pc_r,
  // exception start
  output logic                         exc_start_r,
  output logic [5:0]                   vec_num_r,
  output logic [23:0]                  vec_addr_r,
  output logic                         push_valid_r,
  output tieu_frame_s                  push_frame_r,
  // status
  output logic [2:0]                   cpu_priority_level_r,
  output logic                         priority_level_msb_r,
  output logic                         exec_hold_r,
  output logic [7:0]                   trap_pending_r,
  output logic [15:0]                  reset_control_reg_r,
  output logic [NUM_IRQ-1:0]           irq_flag_regs_r
);

  // ------------------------------------------------------------
  // decoding
  // ------------------------------------------------------------

  // {found, index} of the highest set bit
  function automatic logic [3:0] top_bit(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] one_hot(input logic [2:0] i);
    return 8'h01 << i;
  endfunction

  // ------------------------------------------------------------
  // internal signals
  // ------------------------------------------------------------

  tieu_state_e              state_r;
  logic [7:0]               trap_act_r;
  logic [7:0]               raise;
  logic [7:0]               busy;
  logic [7:0]               hard_clash;
  logic [7:0]               take_mask;
  logic [7:0]               ret_mask;
  logic [7:0]               trap_pending_nxt;
  logic [NUM_IRQ-1:0]       irq_req;
  logic                     irq_valid;
  logic [5:0]               irq_idx;
  logic [2:0]               irq_prio;
  logic [3:0]               cur_lvl;
  logic [3:0]               trap_top;
  logic                     boundary;
  logic                     trap_take;
  logic                     irq_take;
  logic                     take;
  logic                     ret_ok;
  logic                     conflict;
  logic                     illop;
  logic                     rst_req;
  logic [5:0]               vec_nxt;
  logic [23:0]              vt_base;

  // ------------------------------------------------------------
  // trap detection and interrupt selection
  // ------------------------------------------------------------

  tieu_trap_detect u_detect (
    .math_ev         (math_ev),
    .addr_ev         (addr_ev),
    .sp_load         (sp_load),
    .sp_value        (sp_value),
    .stack_limit_reg (stack_limit_reg),
    .osc_fail        (osc_fail),
    .raise           (raise)
  );

  assign irq_req = irq_flag_regs_r & irq_enable_regs; // RULE18

  tieu_irq_select u_select (
    .req      (irq_req),
    .prio     (irq_priority),
    .valid    (irq_valid),
    .idx      (irq_idx),
    .win_prio (irq_prio)
  );

  // ------------------------------------------------------------
  // hard trap conflict
  // ------------------------------------------------------------

  // only traps already latched count; same-cycle ones just queue
  assign busy = trap_pending_r | trap_act_r;

  for (genvar g = 0; g < 8; g++) begin : g_clash
    if (g >= int'(LVL_HARD_MIN[2:0]) && g < 7) begin : g_hard
      assign hard_clash[g] = raise[g] & (|busy[7:g+1]); // RULE17
    end else begin : g_none
      assign hard_clash[g] = 1'b0;
    end
  end

  assign conflict = |hard_clash;
  assign illop = rst_src.illop_exec & ~rst_src.flushed; // RULE3
  assign rst_req = rst_src.wdt | rst_src.uninit | illop | // RULE2
                   rst_src.brownout | rst_src.swreset | conflict;

  // ------------------------------------------------------------
  // take decision
  // ------------------------------------------------------------

  assign cur_lvl  = {priority_level_msb_r, cpu_priority_level_r};
  assign trap_top = top_bit(trap_pending_r); // RULE14
  // exceptions start only between instructions
  assign boundary = instr_done & (state_r == ST_RUN) & // RULE6
                    ~irq_return & ~rst_req;
  assign trap_take = boundary & trap_top[3] &
                     ({1'b1, trap_top[2:0]} > cur_lvl); // RULE4
  // level 7 and any trap level leave no room above
  assign irq_take = boundary & ~trap_take & irq_valid & // RULE5
                    ~priority_level_msb_r &
                    (irq_prio > cpu_priority_level_r); // RULE19
  assign take = trap_take | irq_take;
  assign ret_ok = irq_return & (state_r == ST_RUN) & ~rst_req;

  assign take_mask = trap_take ? one_hot(trap_top[2:0]) : 8'h00;
  assign ret_mask  = (ret_ok & priority_level_msb_r) ?
                     one_hot(cpu_priority_level_r) : 8'h00;

  // new raise beats acknowledge of the same level
  assign trap_pending_nxt = rst_req ? 8'h00 :
                            ((trap_pending_r & ~take_mask) | raise);

  assign vec_nxt = trap_take ? {3'h0, trap_top[2:0]} :
                               6'(irq_idx + IRQ_VEC_OFS);
  assign vt_base = alt_vector_select ? ALT_VT_BASE :
                                       PRI_VT_BASE; // RULE23

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_RUN;
    end else if (rst_req) begin
      state_r <= ST_RESET;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          if (take) begin
            state_r <= ST_EXC;
          end
        end
        ST_EXC: begin
          state_r <= ST_RUN;
        end
        ST_RESET: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  // core held in reset while reset_n is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_reset_r <= 1'b1;
      reset_pc_r   <= RESET_VECTOR;
    end else begin
      core_reset_r <= rst_req; // RULE1
      reset_pc_r   <= RESET_VECTOR;
    end
  end

  // ------------------------------------------------------------
  // trap bookkeeping
  // ------------------------------------------------------------

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trap_pending_r <= 8'h00;
      exec_hold_r    <= 1'b0;
    end else begin
      trap_pending_r <= trap_pending_nxt; // RULE14
      exec_hold_r    <= |trap_pending_nxt[7:4]; // RULE16
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trap_act_r <= 8'h00;
    end else if (rst_req) begin
      trap_act_r <= 8'h00;
    end else begin
      trap_act_r <= (trap_act_r & ~ret_mask) | take_mask;
    end
  end

  // ------------------------------------------------------------
  // priority level
  // ------------------------------------------------------------

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_priority_level_r <= 3'h0;
      priority_level_msb_r <= 1'b0;
    end else if (rst_req) begin
      cpu_priority_level_r <= 3'h0; // RULE1
      priority_level_msb_r <= 1'b0;
    end else if (trap_take) begin
      cpu_priority_level_r <= trap_top[2:0]; // RULE15
      priority_level_msb_r <= 1'b1; // RULE4
    end else if (irq_take) begin
      cpu_priority_level_r <= irq_prio; // RULE20
      priority_level_msb_r <= 1'b0;
    end else if (ret_ok) begin
      cpu_priority_level_r <= pop_frame.stat[7:5]; // RULE22
      priority_level_msb_r <= pop_frame.msb;
    end else if (lvl_wr && state_r == ST_RUN) begin
      // flag must already be cleared or the request re-enters
      cpu_priority_level_r <= lvl_wdata; // RULE21
    end
  end

  // ------------------------------------------------------------
  // exception start and stack frame
  // ------------------------------------------------------------

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      exc_start_r <= 1'b0;
      vec_num_r   <= 6'h00;
      vec_addr_r  <= PRI_VT_BASE;
    end else begin
      exc_start_r <= take;
      if (take) begin
        vec_num_r  <= vec_nxt; // RULE27
        vec_addr_r <= vt_base + {17'h00000, vec_nxt, 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      push_valid_r <= 1'b0;
      push_frame_r <= '0;
    end else begin
      push_valid_r <= take;
      if (take) begin
        push_frame_r.pc  <= pc_in; // RULE20
        push_frame_r.stat <= {cpu_priority_level_r, stat_low};
        push_frame_r.msb <= priority_level_msb_r;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt flags and reset causes
  // ------------------------------------------------------------

  // an event in the clearing cycle survives
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_flag_regs_r <= '0;
    end else if (rst_req) begin
      irq_flag_regs_r <= '0;
    end else begin
      irq_flag_regs_r <= (irq_flag_regs_r & ~irq_flag_clr) |
                         irq_event; // RULE18
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_control_reg_r <= CAUSE_RESET;
    end else begin
      reset_control_reg_r <= reset_control_reg_r & ~cause_clr;
      reset_control_reg_r[CAUSE_CLASH] <= conflict | // RULE17
        (reset_control_reg_r[CAUSE_CLASH] & ~cause_clr[CAUSE_CLASH]);
      reset_control_reg_r[CAUSE_ILLOP] <= illop |
        (reset_control_reg_r[CAUSE_ILLOP] & ~cause_clr[CAUSE_ILLOP]);
      reset_control_reg_r[CAUSE_UNINIT] <= rst_src.uninit |
        (reset_control_reg_r[CAUSE_UNINIT] & ~cause_clr[CAUSE_UNINIT]);
      reset_control_reg_r[CAUSE_SWR] <= rst_src.swreset |
        (reset_control_reg_r[CAUSE_SWR] & ~cause_clr[CAUSE_SWR]);
      reset_control_reg_r[CAUSE_WDT] <= rst_src.wdt |
        (reset_control_reg_r[CAUSE_WDT] & ~cause_clr[CAUSE_WDT]);
      reset_control_reg_r[CAUSE_BROWN] <= rst_src.brownout |
        (reset_control_reg_r[CAUSE_BROWN] & ~cause_clr[CAUSE_BROWN]);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence rst_pulse;
    core_reset_r ##1 (state_r == ST_RUN);
  endsequence

  sequence exc_frame;
    exc_start_r && push_valid_r ##1 !exc_start_r;
  endsequence

  trap_msb_set_a: assert property ( // RULE4
    exc_start_r && vec_num_r < IRQ_VEC_OFS |-> priority_level_msb_r)
    else $error("trap taken without msb");

  illop_reset_a: assert property ( // RULE3
    illop |=> rst_pulse)
    else $error("executed illegal opcode did not reset");

  flushed_quiet_a: assert property ( // RULE3
    rst_src.illop_exec && rst_src.flushed && !rst_src.wdt &&
    !rst_src.uninit && !rst_src.brownout && !rst_src.swreset &&
    !conflict |=> !core_reset_r)
    else $error("flushed illegal opcode caused reset");

  conflict_rst_a: assert property ( // RULE17
    conflict |=> core_reset_r && reset_control_reg_r[CAUSE_CLASH]
             && trap_pending_r == 8'h00)
    else $error("hard trap conflict did not reset");

  irq_vector_a: assert property ( // RULE27
    irq_take |=> exc_frame and
      (vec_num_r == $past(irq_idx) + IRQ_VEC_OFS))
    else $error("wrong interrupt vector number");

  above_level_a: assert property ( // RULE19
    exc_start_r && !priority_level_msb_r |->
      $past(irq_prio) > $past(cpu_priority_level_r))
    else $error("interrupt taken at or below level");

  level7_block_a: assert property ( // RULE5
    cur_lvl == {1'b0, LVL_ALL_OFF} && !trap_top[3] |=> !exc_start_r)
    else $error("interrupt accepted at level 7");

  push_frame_a: assert property ( // RULE20
    take |=> push_frame_r.stat[7:5] == $past(cpu_priority_level_r)
          && push_frame_r.pc == $past(pc_in))
    else $error("stack frame content wrong");

  return_pop_a: assert property ( // RULE22
    ret_ok |=> cpu_priority_level_r == $past(pop_frame.stat[7:5])
            && priority_level_msb_r == $past(pop_frame.msb))
    else $error("return did not restore level");

  hard_hold_a: assert property ( // RULE16
    |raise[7:4] && !rst_req |=> exec_hold_r)
    else $error("hard trap did not hold execution");

  stack_trap_a: assert property ( // RULE12
    sp_load && sp_value < STACK_FLOOR && !rst_req |=>
      trap_pending_r[IDX_STACK])
    else $error("stack underflow not flagged");

  alt_table_a: assert property ( // RULE23
    take && alt_vector_select |=> vec_addr_r >= ALT_VT_BASE)
    else $error("alternate table not used");

  flag_sample_a: assert property ( // RULE18
    !rst_req |=> (irq_flag_regs_r & $past(irq_event))
                 == $past(irq_event))
    else $error("event flag lost");

endmodule

// ### verilog/tieu_pkg.sv
package tieu_pkg;

// Contract
// RULE1: reset zeroes state, execution starts at word 0
// RULE2: six error sources trap to reset vector
// RULE3: illegal opcode traps only when really executed
// RULE4: traps use levels 8-15, msb set
// RULE5: level 7 blocks interrupts, traps still taken
// RULE6: offending instruction completes before trap processing
// RULE7: divide by zero, oversized shift raise math trap
// RULE8: enabled accumulator overflows raise math trap
// RULE9: misaligned, unimplemented, vector fetch raise address trap
// RULE10: bad branch target or pc raises address trap
// RULE11: dual-space accesses treat other space unimplemented
// RULE12: stack pointer above limit or below floor traps
// RULE13: oscillator fallback raises oscillator fail trap
// RULE14: simultaneous traps served by priority, rest pending
// RULE15: soft levels 8-11, hard levels 12-15
// RULE16: hard trap suspends execution until acknowledged
// RULE17: lower hard trap during higher trap resets
// RULE18: flags sampled each cycle, gated by enables
// RULE19: interrupt only above current cpu priority level
// RULE20: push pc and status low byte, raise level
// RULE21: software clears flag before lowering priority
// RULE22: return instruction pops pc and status
// RULE23: alternate table used when select bit set
// RULE24: invalid trap vector raises address trap
// RULE25: user priorities run 0 lowest to 7
// RULE26: equal priority ties go to lower vector
// RULE27: vector number presented when exception starts

localparam int          NUM_IRQ      = 54;
localparam logic [3:0]  LVL_HARD_MIN = 4'hc;
localparam int          IDX_MATH     = 3;
localparam int          IDX_ADDR     = 4;
localparam int          IDX_STACK    = 5;
localparam int          IDX_OSC      = 6;
localparam logic [2:0]  LVL_ALL_OFF  = 3'h7;
localparam logic [15:0] STACK_FLOOR  = 16'h0800;
localparam logic [23:0] RESET_VECTOR = 24'h000000;
localparam logic [23:0] PRI_VT_BASE  = 24'h000004;
localparam logic [23:0] ALT_VT_BASE  = 24'h000084;
localparam logic [5:0]  IRQ_VEC_OFS  = 6'h08;
localparam logic [15:0] CAUSE_RESET  = 16'h0000;
localparam int          CAUSE_CLASH  = 15;
localparam int          CAUSE_ILLOP  = 14;
localparam int          CAUSE_UNINIT = 13;
localparam int          CAUSE_SWR    = 6;
localparam int          CAUSE_WDT    = 4;
localparam int          CAUSE_BROWN  = 1;

typedef enum logic [1:0] {ST_RUN, ST_EXC, ST_RESET} tieu_state_e;

typedef struct packed {
  logic div_zero;
  logic shift_big;
  logic acc_ovf31;
  logic guard_used;
  logic acc_ovf39;
  logic sat_off;
  logic ovf_trap_en;
} tieu_math_s;

typedef struct packed {
  logic misaligned;
  logic data_unimpl;
  logic prog_unimpl;
  logic fetch_vec;
  logic bra_unimpl;
  logic pc_unimpl;
  logic mac_x;
  logic in_y;
  logic mac_y;
  logic in_x;
  logic vec_invalid;
} tieu_addr_s;

typedef struct packed {
  logic wdt;
  logic uninit;
  logic illop_exec;
  logic flushed;
  logic brownout;
  logic swreset;
} tieu_rst_s;

typedef struct packed {
  logic [23:0] pc;
  logic [7:0]  stat;
  logic        msb;
} tieu_frame_s;

endpackage

// ### verilog/tieu_trap_detect.sv
`timescale 1ns/10ps
module tieu_trap_detect
  import tieu_pkg::*;
(
  // trap conditions
  input  wire tieu_math_s  math_ev,
  input  wire tieu_addr_s  addr_ev,
  input  wire logic        sp_load,
  input  wire logic [15:0] sp_value,
  input  wire logic [15:0] stack_limit_reg,
  input  wire logic        osc_fail,
  // one bit per level 8..15
  output logic [7:0]       raise
);

  logic ovf;
  logic xy_cross;

  // overflow only counts when the enable is set
  assign ovf = math_ev.ovf_trap_en &
               ((math_ev.acc_ovf31 & ~math_ev.guard_used) | // RULE8
                (math_ev.acc_ovf39 & math_ev.sat_off));
  assign xy_cross = (addr_ev.mac_x & addr_ev.in_y) |
                    (addr_ev.mac_y & addr_ev.in_x); // RULE11

  always_comb begin
    raise = 8'h00;
    raise[IDX_MATH] = math_ev.div_zero | math_ev.shift_big | ovf; // RULE7
    raise[IDX_ADDR] = addr_ev.misaligned | addr_ev.data_unimpl |
                      addr_ev.prog_unimpl | addr_ev.fetch_vec | // RULE9
                      addr_ev.bra_unimpl | addr_ev.pc_unimpl | // RULE10
                      addr_ev.vec_invalid | xy_cross; // RULE24
    raise[IDX_STACK] = sp_load & ((sp_value > stack_limit_reg) |
                                  (sp_value < STACK_FLOOR)); // RULE12
    raise[IDX_OSC] = osc_fail; // RULE13
  end

endmodule

// ### verilog/tieu_irq_select.sv
`timescale 1ns/10ps
module tieu_irq_select
  import tieu_pkg::*;
(
  // requests and priorities
  input  wire logic [NUM_IRQ-1:0]      req,
  input  wire logic [NUM_IRQ-1:0][2:0] prio,
  // winner
  output logic                         valid,
  output logic [5:0]                   idx,
  output logic [2:0]                   win_prio
);

  // walking downward with >= lets the lower index win a tie
  always_comb begin
    valid    = 1'b0;
    idx      = 6'h00;
    win_prio = 3'h0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i] && (!valid || prio[i] >= win_prio)) begin // RULE26
        valid    = 1'b1;
        idx      = 6'(i);
        win_prio = prio[i]; // RULE25
      end
    end
  end

endmodule

// ### bench/tieu_core_model.sv
`timescale 1ns/10ps
module tieu_core_model
  import tieu_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // from the unit, plus the bench stall
  input  wire logic        core_reset_r,
  input  wire logic        push_valid_r,
  input  wire tieu_frame_s push_frame_r,
  input  wire logic        stall,
  // towards the unit
  output logic             instr_done,
  output logic [23:0]      pc_in,
  output logic [4:0]       stat_low,
  output logic             irq_return,
  output tieu_frame_s      pop_frame
);
  tieu_frame_s stk[$];

  initial begin
    irq_return = 1'b0;
    pop_frame  = '0;
  end

  // ---------------------------------------------
  // sequencer: boundaries come late at random
  // ---------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      instr_done <= 1'b0;
      pc_in      <= 24'h000000;
      stat_low   <= 5'h00;
    end else begin
      instr_done <= !stall && ($urandom % 4 != 0);
      stat_low   <= 5'($urandom);
      if (instr_done) begin
        pc_in <= pc_in + 24'h000002;
      end
    end
  end

  // ---------------------------------------------
  // frame stack
  // ---------------------------------------------
  always @(posedge clk) begin
    if (core_reset_r) begin
      stk.delete();
    end else if (push_valid_r) begin
      stk.push_back(push_frame_r);
    end
  end

  // released frame bus shows the inverse, never a stale copy;
  // hands back at a falling edge so callers never race the clock
  task automatic ret;
    @(posedge clk);
    irq_return <= 1'b1;
    pop_frame  <= stk.pop_back();
    @(posedge clk);
    irq_return <= 1'b0;
    pop_frame  <= tieu_frame_s'(~pop_frame);
    @(negedge clk);
  endtask
endmodule

// ### bench/tb_trap_interrupt_exception_unit.sv
`timescale 1ns/10ps
module tb_trap_interrupt_exception_unit;
  import tieu_pkg::*;
  logic                    clk, reset_n, stall, sp_load, osc_fail, lvl_wr;
  logic                    instr_done, irq_return, alt_vector_select;
  logic                    core_reset_r, exc_start_r, push_valid_r;
  logic                    priority_level_msb_r, exec_hold_r;
  tieu_rst_s               rst_src;
  tieu_math_s              math_ev;
  tieu_addr_s              addr_ev;
  tieu_frame_s             pop_frame, push_frame_r;
  logic [15:0]             sp_value, stack_limit_reg, cause_clr;
  logic [15:0]             reset_control_reg_r;
  logic [23:0]             pc_in, reset_pc_r, vec_addr_r;
  logic [4:0]              stat_low;
  logic [2:0]              lvl_wdata, cpu_priority_level_r;
  logic [5:0]              vec_num_r;
  logic [7:0]              trap_pending_r;
  logic [NUM_IRQ-1:0]      irq_event, irq_flag_clr, irq_enable_regs;
  logic [NUM_IRQ-1:0]      irq_flag_regs_r;
  logic [NUM_IRQ-1:0][2:0] irq_priority;
  logic [37:0]             exc_q[$];
  logic [15:0]             rst_q[$];
  int                      mismatches, samples_checked, cycles, a, b, p;
  logic [9:0]              rtab[6] = '{10'h204, 10'h10d, 10'h08e, 10'h021,
                                       10'h016, 10'h0c0};
  logic [7:0]              mtab[7] = '{8'hc0, 8'ha0, 8'h91, 8'h19, 8'h87,
                                       8'h05, 8'h10};
  logic [10:0]             atab[10] = '{11'h400, 11'h200, 11'h100, 11'h080,
                                        11'h040, 11'h020, 11'h001, 11'h018,
                                        11'h006, 11'h010};

  // bench nets carry the port names, so both connect by name
  tieu_unit       dut_u (.*);
  tieu_core_model core_u (.*);

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic chk(input string what, input logic [39:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic void quiet;
    {rst_src, math_ev, addr_ev, sp_load, osc_fail, lvl_wr} = '0;
    {irq_event, irq_flag_clr, cause_clr} = '0;
  endfunction

  // pulses live exactly one cycle
  task automatic step;
    @(negedge clk);
    quiet();
  endtask

  task automatic note(input logic [5:0] v, input logic [2:0] lvl,
                      input logic msb, input logic [2:0] old);
    logic [23:0] base;
    base = alt_vector_select ? ALT_VT_BASE : PRI_VT_BASE;
    exc_q.push_back({1'b1, v, base + {17'h0, v, 1'b0}, lvl, msb, old});
  endtask

  task automatic trap(input int lvl, input logic [2:0] old);
    note(6'(lvl - 8), 3'(lvl), 1'b1, old);
  endtask

  task automatic drain;
    for (int n = 0; n < 60 && exc_q.size() + rst_q.size() > 0; n++) step;
    step;
    step;
    chk("queue", 40'(exc_q.size() + rst_q.size()), 40'h0);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  // ---------------------------------------------
  // result watcher
  // ---------------------------------------------
  always @(posedge clk) begin
    #1;
    if (reset_n && exc_start_r) begin
      if (exc_q.size() == 0) chk("stray exception", 40'h1, 40'h0);
      else chk("exception", {push_valid_r, vec_num_r, vec_addr_r,
               cpu_priority_level_r, priority_level_msb_r,
               push_frame_r.stat[7:5]}, exc_q.pop_front());
    end
    if (reset_n && core_reset_r) begin
      if (rst_q.size() == 0) chk("stray reset", 40'h1, 40'h0);
      else chk("cause", reset_control_reg_r, rst_q.pop_front());
    end
  end

  initial begin
    void'($urandom(99));
    quiet();
    {reset_n, stall, alt_vector_select, lvl_wdata, sp_value} = '0;
    {irq_enable_regs, irq_priority, mismatches, samples_checked} = '0;
    cycles = 0;
    stack_limit_reg = 16'h1000;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    step;
    step;
    chk("reset pc", reset_pc_r, RESET_VECTOR);
    chk("core reset", core_reset_r, 40'h0);
    foreach (rtab[i]) begin
      cause_clr = 16'hffff;
      step;
      rst_src = tieu_rst_s'(rtab[i][9:4]);
      if (rtab[i][9:4] != 6'h0c) rst_q.push_back(16'h1 << rtab[i][3:0]);
      step;
      drain();
      if (rtab[i][9:4] == 6'h0c)
        chk("flushed op", reset_control_reg_r, 40'h0);
    end
    // hard trap must wait for the boundary
    {stall, sp_load, sp_value} = {2'b11, 16'($urandom % 16'h0800)};
    step;
    step;
    chk("exec hold", exec_hold_r, 40'h1);
    chk("pending", trap_pending_r, 40'h20);
    trap(13, 3'h0);
    stall = 1'b0;
    drain();
    core_u.ret();
    chk("level back", {priority_level_msb_r, cpu_priority_level_r},
        40'h0);
    {sp_load, math_ev.div_zero} = 2'b11;
    sp_value = stack_limit_reg + 16'h0002;
    step;
    trap(13, 3'h0);
    drain();
    trap(11, 3'h0);
    core_u.ret();
    drain();
    core_u.ret();
    foreach (mtab[i]) begin
      math_ev = tieu_math_s'(mtab[i][6:0]);
      step;
      if (mtab[i][7]) trap(11, 3'h0);
      drain();
      if (mtab[i][7]) core_u.ret();
    end
    foreach (atab[i]) begin
      alt_vector_select = 1'($urandom);
      addr_ev = tieu_addr_s'(atab[i]);
      step;
      if (atab[i] != 11'h010) trap(12, 3'h0);
      drain();
      if (atab[i] != 11'h010) core_u.ret();
    end
    // lower hard trap while a higher one is in service
    {osc_fail, cause_clr} = {1'b1, 16'hffff};
    step;
    trap(14, 3'h0);
    drain();
    {sp_load, sp_value} = {1'b1, 16'h0000};
    rst_q.push_back(16'h8000);
    step;
    drain();
    chk("after conflict", {trap_pending_r, priority_level_msb_r,
        cpu_priority_level_r}, 40'h0);
    irq_enable_regs = '1;
    a = $urandom % 20;
    b = a + 1 + $urandom % 30;
    p = 2 + $urandom % 5;
    {irq_priority[a], irq_priority[b]} = {3'(p), 3'(p)};
    {lvl_wr, lvl_wdata} = {1'b1, 3'h1};
    step;
    {irq_event[a], irq_event[b]} = 2'b11;
    step;
    note(6'(a + 8), 3'(p), 1'b0, 3'h1);
    drain();
    irq_flag_clr[a] = 1'b1;
    step;
    note(6'(b + 8), 3'(p), 1'b0, 3'h1);
    core_u.ret();
    drain();
    irq_flag_clr[b] = 1'b1;
    step;
    core_u.ret();
    chk("restored level", cpu_priority_level_r, 40'h1);
    // equal level waits, disabled source never requests
    {lvl_wr, lvl_wdata} = {1'b1, 3'(p)};
    irq_enable_regs[a] = 1'b0;
    step;
    {irq_event[a], irq_event[b]} = 2'b11;
    step;
    drain();
    chk("flags", {irq_flag_regs_r[a], irq_flag_regs_r[b]},
        40'h3);
    {lvl_wr, lvl_wdata} = {1'b1, 3'(p - 1)};
    step;
    note(6'(b + 8), 3'(p), 1'b0, 3'(p - 1));
    drain();
    irq_flag_clr = '1;
    step;
    core_u.ret();
    irq_enable_regs = '1;
    irq_priority[a] = 3'h7;
    {lvl_wr, lvl_wdata} = {1'b1, LVL_ALL_OFF};
    step;
    {irq_event[a], math_ev.div_zero} = 2'b11;
    step;
    trap(11, 3'h7);
    drain();
    core_u.ret();
    drain();
    chk("blocked", {irq_flag_regs_r[a], cpu_priority_level_r},
        40'hf);
    conclude();
  end
endmodule
